// *** inc/ds3_maint_pkg.sv ***
// Constants for the DS3 transmit maintenance and overhead override block.
// Operation
// - Yellow command forces all X-bits to zero.
// - Yellow ignored under LOS, AIS or idle.
// - Force-high command sets all X-bits to one.
// - Force-high ignored under LOS, AIS, idle, yellow.
// - Idle: CP-bits zero, X one, 1100 payload.
// - Idle ignored under LOS or AIS.
// - AIS: C-bits zero, X one, 1010 payload.
// - Simulated LOS sends an all-zero line.
// - Receive LOS raises yellow when enabled.
// - Receive OOF raises yellow when enabled.
// - Receive AIS raises yellow when enabled.
package ds3_maint_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [7:0] CFG_ADDR    = 8'h30;
	localparam logic [7:0] CFG_RESET   = 8'h07;
	localparam logic [7:0] RDATA_NONE  = 8'h00;
	localparam int         BIT_YELLOW  = 7;
	localparam int         BIT_XHIGH   = 6;
	localparam int         BIT_IDLE    = 5;
	localparam int         BIT_AIS     = 4;
	localparam int         BIT_LOS     = 3;
	localparam int         BIT_ON_LOS  = 2;
	localparam int         BIT_ON_OOF  = 1;
	localparam int         BIT_ON_AIS  = 0;

	// -----------------------------------------------------------------
	// Overhead bit classes presented with each stream bit
	// -----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		BK_PAYLOAD = 3'b000,
		BK_X       = 3'b001,
		BK_C       = 3'b010,
		BK_CP      = 3'b011,
		BK_MFP     = 3'b100
	} bit_kind_e;

	// Payload fill patterns, sent most significant bit first.
	localparam int                FILL_W   = 4;
	localparam logic [FILL_W-1:0] IDLE_PAT = 4'hC;
	localparam logic [FILL_W-1:0] AIS_PAT  = 4'hA;

endpackage : ds3_maint_pkg

// *** core/ds3_pattern_gen.sv ***
// Repeating multi-bit payload pattern generator for idle and AIS fill.
`timescale 1ns/100ps
module ds3_pattern_gen
#(
	parameter int PAT_W = 4
)
(
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic             adv_i,
	input  wire logic [PAT_W-1:0] pat_i,
	output logic                  bit_o
);
	localparam int              PH_W    = $clog2(PAT_W);
	localparam logic [PH_W-1:0] PH_LAST = PH_W'(PAT_W - 1);

	logic [PH_W-1:0] phase_q;

	// Phase restarts at reset so the pattern opens with its first bit after reset, not at each fill start.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			phase_q <= '0;
		else if (adv_i)
			phase_q <= (phase_q == PH_LAST) ? '0 : PH_W'(phase_q + 1'b1);
	end

	// The pattern is sent from its most significant bit down.
	assign bit_o = pat_i[PH_LAST - phase_q];
endmodule : ds3_pattern_gen

// *** core/ds3_tx_maintenance_overhead.sv ***
// Transmit maintenance signal and overhead override for one DS3 channel.
`timescale 1ns/100ps
module ds3_tx_maintenance_overhead
(
	input  wire logic                          clk_i,
	input  wire logic                          srst_i,
	input  wire logic [7:0]                    addr_i,
	input  wire logic [7:0]                    wdata_i,
	input  wire logic                          wr_i,
	input  wire logic                          rd_i,
	output logic      [7:0]                    rdata_o,
	input  wire logic                          rx_los_i,
	input  wire logic                          rx_oof_i,
	input  wire logic                          rx_ais_i,
	input  wire logic                          bit_valid_i,
	input  wire logic                          bit_i,
	input  wire ds3_maint_pkg::bit_kind_e      bit_kind_i,
	output logic                               bit_valid_o,
	output logic                               bit_o,
	output logic                               remote_alarm_o
);
	import ds3_maint_pkg::*;

	// -----------------------------------------------------------------
	// Configuration register
	// -----------------------------------------------------------------
	logic [7:0] cfg_q;
	logic [7:0] rdata_q;
	wire        sel = (addr_i == CFG_ADDR);
	// Writes to any other address are dropped here and leave the register alone.
	wire        cfg_we = wr_i && sel;

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			cfg_q <= CFG_RESET;
		else if (cfg_we)
			cfg_q <= wdata_i;
	end

	// Unmapped addresses read as zero, so software probing the map sees no ghost copies.
	// The read data hold until the next read strobe.
	wire [7:0]  rdata_d = sel ? cfg_q : RDATA_NONE;

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			rdata_q <= RDATA_NONE;
		else if (rd_i)
			rdata_q <= rdata_d;
	end
	assign rdata_o = rdata_q;

	// -----------------------------------------------------------------
	// Command priority
	// -----------------------------------------------------------------
	wire simulate_signal_loss          = cfg_q[BIT_LOS];
	wire send_alarm_indication_pattern = cfg_q[BIT_AIS] && !simulate_signal_loss;
	wire send_idle                     = cfg_q[BIT_IDLE] && !cfg_q[BIT_LOS] && !cfg_q[BIT_AIS];
	wire override_any                  = cfg_q[BIT_LOS] || cfg_q[BIT_AIS] || cfg_q[BIT_IDLE];

	wire remote_alarm_on_signal_loss      = cfg_q[BIT_ON_LOS] && rx_los_i;
	wire remote_alarm_on_frame_loss       = cfg_q[BIT_ON_OOF] && rx_oof_i;
	wire remote_alarm_on_alarm_indication = cfg_q[BIT_ON_AIS] && rx_ais_i;
	wire auto_yellow = remote_alarm_on_signal_loss || remote_alarm_on_frame_loss
		|| remote_alarm_on_alarm_indication;

	// Priority from the top: simulated loss of signal, AIS, idle, yellow (manual
	// or automatic), force-high. Each command is masked by every one above it, so
	// the line never carries a mix of two maintenance patterns.
	// Auto alarm is level-driven, so it ends as soon as the receive condition clears.
	wire yellow  = (cfg_q[BIT_YELLOW] || auto_yellow) && !override_any;
	wire x_high  = cfg_q[BIT_XHIGH] && !override_any && !cfg_q[BIT_YELLOW];

	// -----------------------------------------------------------------
	// Payload fill pattern
	// -----------------------------------------------------------------
	// The fill phase counts every payload bit since reset, fill or not, so it does
	// not restart when a fill command is set; this keeps the generator free of any
	// dependence on the command history.
	wire              fill_bit;
	wire [FILL_W-1:0] fill_pat = send_alarm_indication_pattern ? AIS_PAT : IDLE_PAT;
	wire              is_pay   = (bit_kind_i == BK_PAYLOAD);

	ds3_pattern_gen
	#(
		.PAT_W  (FILL_W)
	)
	u_pat
	(
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.adv_i  (bit_valid_i && is_pay),
		.pat_i  (fill_pat),
		.bit_o  (fill_bit)
	);

	// -----------------------------------------------------------------
	// Bit override
	// -----------------------------------------------------------------
	logic out_d;
	always_comb
	begin
		out_d = bit_i;
		if (simulate_signal_loss)
			out_d = 1'b0;
		else if (send_alarm_indication_pattern)
		begin
			unique case (bit_kind_i)
				BK_PAYLOAD: out_d = fill_bit;
				BK_X:       out_d = 1'b1;
				BK_C, BK_CP: out_d = 1'b0;
				default:    out_d = bit_i;
			endcase
		end
		else if (send_idle)
		begin
			unique case (bit_kind_i)
				BK_PAYLOAD: out_d = fill_bit;
				BK_X:       out_d = 1'b1;
				BK_CP:      out_d = 1'b0;
				default:    out_d = bit_i;
			endcase
		end
		else if (bit_kind_i == BK_X)
		begin
			if (yellow)
				out_d = 1'b0;
			else if (x_high)
				out_d = 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Line output registers
	// -----------------------------------------------------------------
	logic valid_q;
	logic bit_q;
	logic alarm_q;

	// The valid flag follows every taken bit one cycle later, so the line side
	// sees exactly the spacing of the incoming stream.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			valid_q <= 1'b0;
		else
			valid_q <= bit_valid_i;
	end

	// The line bit holds between valid bits, so a gap in the stream shows no
	// spurious mark to the line interface.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			bit_q <= 1'b0;
		else if (bit_valid_i)
			bit_q <= out_d;
	end

	// The alarm flag is the effective yellow state, manual or automatic, after
	// the higher-priority commands have masked it.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			alarm_q <= 1'b0;
		else
			alarm_q <= yellow;
	end

	assign bit_valid_o    = valid_q;
	assign bit_o          = bit_q;
	assign remote_alarm_o = alarm_q;
endmodule : ds3_tx_maintenance_overhead

// *** test/ds3_tx_maint_asserts.sv ***
// Port-level checker of the transmit maintenance override block.
`timescale 1ns/100ps
module ds3_tx_maint_asserts
(
	input wire logic                     clk_i,
	input wire logic                     srst_i,
	input wire logic [7:0]               addr_i,
	input wire logic [7:0]               wdata_i,
	input wire logic                     wr_i,
	input wire logic                     rx_los_i,
	input wire logic                     rx_oof_i,
	input wire logic                     rx_ais_i,
	input wire logic                     bit_valid_i,
	input wire logic                     bit_i,
	input wire ds3_maint_pkg::bit_kind_e bit_kind_i,
	input wire logic                     bit_valid_o,
	input wire logic                     bit_o,
	input wire logic                     remote_alarm_o
);
	import ds3_maint_pkg::*;
	// The checker mirrors the register so that it needs no read traffic.
	logic [7:0] cfg_q;
	logic ovr;
	logic yel;
	logic vx;
	assign ovr = |cfg_q[5:3];
	assign yel = !ovr && (cfg_q[7] || (cfg_q[2] && rx_los_i) || (cfg_q[1] && rx_oof_i) || (cfg_q[0] && rx_ais_i));
	assign vx = bit_valid_i && bit_kind_i == BK_X;
	always_ff @(posedge clk_i)
		cfg_q <= srst_i ? CFG_RESET : (wr_i && addr_i == CFG_ADDR) ? wdata_i : cfg_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	los_zero_a: assert property (bit_valid_i && cfg_q[3] |=> !bit_o) else $error("line not zero");
	ais_x_a: assert property (vx && cfg_q[4:3] == 2'h2 |=> bit_o) else $error("ais x bit");
	ais_c_a: assert property (bit_valid_i && cfg_q[4:3] == 2'h2 && bit_kind_i inside {BK_C, BK_CP}
		|=> !bit_o) else $error("ais c bit");
	idle_cp_a: assert property (bit_valid_i && cfg_q[5:3] == 3'h4 && bit_kind_i == BK_CP |=> !bit_o)
		else $error("idle cp bit");
	mfp_pass_a: assert property (bit_valid_i && !cfg_q[3] && bit_kind_i == BK_MFP |=> bit_o == $past(bit_i))
		else $error("framing bit");
	yel_x_a: assert property (vx && yel |=> !bit_o) else $error("yellow x bit");
	xhigh_a: assert property (vx && cfg_q[6] && !ovr && !yel |=> bit_o) else $error("x high");
	alarm_out_a: assert property (1'h1 |=> remote_alarm_o == $past(yel)) else $error("alarm flag");
	// Fill phase mirror: one step per payload bit, wrapping with the four-bit pattern.
	logic [1:0] ph_q;
	logic       vp;
	logic       fill_e;
	assign vp = bit_valid_i && bit_kind_i == BK_PAYLOAD;
	assign fill_e = cfg_q[4] ? AIS_PAT[2'h3 - ph_q] : IDLE_PAT[2'h3 - ph_q];
	always_ff @(posedge clk_i)
		ph_q <= srst_i ? 2'h0 : ph_q + 2'(vp);
	idle_x_a: assert property (vx && cfg_q[5:3] == 3'h4 |=> bit_o) else $error("idle x bit");
	fill_pay_a: assert property (vp && !cfg_q[3] && cfg_q[5:4] != 2'h0 |=> bit_o == $past(fill_e))
		else $error("fill payload");
	valid_lat_a: assert property (1'h1 |=> bit_valid_o == $past(bit_valid_i)) else $error("valid lag");
endmodule : ds3_tx_maint_asserts

// *** test/liu_model.sv ***
// Line side receiver that captures each transmitted bit.
`timescale 1ns/100ps
module liu_model
(
	input  wire logic clk_i,
	input  wire logic valid_i,
	input  wire logic data_i,
	output logic      last_o
);
	always_ff @(posedge clk_i)
		if (valid_i)
			last_o <= data_i;
endmodule : liu_model

// *** test/testbench.sv ***
// Self-checking bench for the transmit maintenance override block.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; $display("ERROR %0t mismatch", $time); end end
module testbench;
	import ds3_maint_pkg::*;
	logic clk_i = '0, srst_i = '1, wr_i = '0, rd_i = '0, bit_valid_i = '0, bit_i = '0, p;
	logic rx_los_i = '0, rx_oof_i = '0, rx_ais_i = '0, bit_valid_o, bit_o, remote_alarm_o, seen;
	logic [7:0] addr_i = '0, wdata_i = '0, rdata_o;
	bit_kind_e bit_kind_i = BK_PAYLOAD;
	int failures = 0, n_checks = 0, cyc = 0, npay = 0;
	logic [12:0] tv [10] = '{{8'h00, BK_PAYLOAD, 2'h3}, {8'h80, BK_X, 2'h2}, {8'hC0, BK_X, 2'h2},
		{8'h40, BK_X, 2'h1}, {8'hA0, BK_X, 2'h1}, {8'hE0, BK_CP, 2'h2}, {8'h30, BK_C, 2'h2},
		{8'h10, BK_X, 2'h1}, {8'h98, BK_MFP, 2'h2}, {8'h10, BK_MFP, 2'h3}};
	ds3_tx_maintenance_overhead uut
	(
		.clk_i          (clk_i),
		.srst_i         (srst_i),
		.addr_i         (addr_i),
		.wdata_i        (wdata_i),
		.wr_i           (wr_i),
		.rd_i           (rd_i),
		.rdata_o        (rdata_o),
		.rx_los_i       (rx_los_i),
		.rx_oof_i       (rx_oof_i),
		.rx_ais_i       (rx_ais_i),
		.bit_valid_i    (bit_valid_i),
		.bit_i          (bit_i),
		.bit_kind_i     (bit_kind_i),
		.bit_valid_o    (bit_valid_o),
		.bit_o          (bit_o),
		.remote_alarm_o (remote_alarm_o)
	);
	liu_model liu (.clk_i, .valid_i(bit_valid_o), .data_i(bit_o), .last_o(seen));
	always #12.5 clk_i = !clk_i;
	always @(posedge clk_i) if (++cyc == 2000) begin failures++; tally_and_finish(); end
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i) #1 {addr_i, wdata_i, wr_i} = {a, d, 1'h1};
		@(posedge clk_i) #1 wr_i = '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, e);
		@(posedge clk_i) #1 {addr_i, rd_i} = {a, 1'h1};
		@(posedge clk_i) #1 rd_i = '0;
		`CHK(rdata_o, e)
	endtask : rd
	// The bit is checked where the line receiver saw it, one edge after the output.
	task automatic send(input bit_kind_e k, input logic b);
		@(posedge clk_i) #1;
		bit_kind_i = k;
		bit_i = b;
		bit_valid_i = 1'h1;
		@(posedge clk_i) #1 bit_valid_i = '0;
		@(posedge clk_i) #1;
		npay += int'(k == BK_PAYLOAD);
	endtask : send
	task tally_and_finish();
		if (failures == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (20) @(posedge clk_i);
		#1 srst_i = '0;
		rd(CFG_ADDR, CFG_RESET);
		wr(8'h31, 8'hFF);
		rd(8'h31, 8'h00);
		wr(CFG_ADDR, 8'h5A);
		rd(CFG_ADDR, 8'h5A);
		for (int i = 0; i < 10; i++)
		begin
			wr(CFG_ADDR, tv[i][12:5]);
			send(bit_kind_e'(tv[i][4:2]), tv[i][1]);
			`CHK(seen, tv[i][0])
		end
		send(BK_PAYLOAD, 1'h1);
		p = seen;
		send(BK_PAYLOAD, 1'h1);
		`CHK(p ^ seen, 1'h1)
		// Payload fill is checked bit by bit against the phase counted from reset.
		for (int m = 0; m < 2; m++)
		begin
			wr(CFG_ADDR, m == 0 ? 8'h10 : 8'h20);
			repeat (4)
			begin
				p = m == 0 ? AIS_PAT[3 - npay % 4] : IDLE_PAT[3 - npay % 4];
				send(BK_PAYLOAD, 1'h0);
				`CHK(seen, p)
			end
		end
		for (int i = 0; i < 3; i++)
			for (int j = 0; j < 3; j++)
			begin
				wr(CFG_ADDR, j == 1 ? 8'h00 : (8'h01 << i) | (j == 2 ? 8'h20 : 8'h00));
				{rx_los_i, rx_oof_i, rx_ais_i} = 3'h1 << i;
				send(BK_X, 1'h1);
				`CHK({seen, remote_alarm_o}, j == 0 ? 2'h1 : 2'h2)
			end
		wr(CFG_ADDR, 8'h04);
		send(BK_X, 1'h1);
		`CHK({seen, remote_alarm_o}, 2'h1)
		{rx_los_i, rx_oof_i, rx_ais_i} = 3'h0;
		send(BK_X, 1'h1);
		`CHK({seen, remote_alarm_o}, 2'h2)
		tally_and_finish();
	end
endmodule : testbench
bind ds3_tx_maintenance_overhead ds3_tx_maint_asserts chk
(
	.clk_i          (clk_i),
	.srst_i         (srst_i),
	.addr_i         (addr_i),
	.wdata_i        (wdata_i),
	.wr_i           (wr_i),
	.rx_los_i       (rx_los_i),
	.rx_oof_i       (rx_oof_i),
	.rx_ais_i       (rx_ais_i),
	.bit_valid_i    (bit_valid_i),
	.bit_i          (bit_i),
	.bit_kind_i     (bit_kind_i),
	.bit_valid_o    (bit_valid_o),
	.bit_o          (bit_o),
	.remote_alarm_o (remote_alarm_o)
);
